// ==== common/ertr_map.vh ====
// Register map, field positions, reset values and timing counts of the echo
// receive, fault and timing register block. Definitions only; included by name.
`ifndef ERTR_MAP_VH
`define ERTR_MAP_VH

// Register indices; byte address is four times the index
`define ERTR_IDX_GAIN_WIN   6'h05
`define ERTR_IDX_WIN_LO     6'h06
`define ERTR_IDX_FAULT      6'h07
`define ERTR_IDX_LIMITS     6'h08

// Reset values
`define ERTR_RST_GAIN_WIN   8'h00
`define ERTR_RST_WIN_LO     8'h00
`define ERTR_RST_FAULT      3'h0
`define ERTR_RST_LIMITS     8'h19

// Gain and window-high register fields
`define ERTR_GAIN_MSB       7
`define ERTR_GAIN_LSB       5
`define ERTR_AMP_BYP        4
`define ERTR_IAMP_BYP       3
`define ERTR_IAMP_FB        2
`define ERTR_WIN_HI_MSB     1

// Fault register fields
`define ERTR_FLT_WEAK       2
`define ERTR_FLT_MISSING    1
`define ERTR_FLT_STRONG     0

// Window limits register fields
`define ERTR_LIM_FORCE      6
`define ERTR_LIM_BLANK_MSB  5
`define ERTR_LIM_BLANK_LSB  3
`define ERTR_LIM_TO_DIS     2
`define ERTR_LIM_WIN_MSB    1

// Timing counts in base periods and the largest threshold code
`define ERTR_BLANK_BASE     11'h008
`define ERTR_WINDOW_BASE    11'h080
`define ERTR_THLD_MAX       3'h7

`endif

// ==== hdl/ertr_regs.v ====
// Echo receive, fault and timing registers with their measurement timer.
// Assumes an APB master on pclk; echo and start pins are asynchronous.
//
// Functional notes
// - Gain field bits 7:5 selects 0 dB to 21 dB in 3 dB steps.
// - Bit 4 set bypasses and powers off the programmable amplifier.
// - Bit 3 set bypasses and powers off the low-noise amplifier.
// - Bit 2 picks amplifier feedback: capacitive at 0, resistive at 1.
// - Offset 5 bits 1:0 hold the two top timing value bits.
// - Offset 6 holds the low eight timing value bits.
// - Weak flag sets on timeout with at least one echo but fewer than expected.
// - Missing flag sets on timeout with no echo at all.
// - Writing 1 to missing flag aborts measurement, returns to idle.
// - Same write clears averaging counter and channel selection state.
// - Strong flag sets when echo amplitude exceeds the largest threshold.
// - Strong flag only reported while threshold code is 0x07.
// - Writing 1 to strong flag clears all flags, releases fault pin.
// - Fault register bits 7:3 read as zero.
// - Limits bit 6 forces a short flight measurement.
// - Bits 5:3 set short flight blanking 8 to 1024 periods, reset 3.
// - Limits bit 2 at 0 enables listen timeout, at 1 disables it.
// - Bits 1:0 set listen window 128 to 1024 periods, reset 1.
// - Base period is pclk divided by one or two.
// - Threshold code 7 is the largest comparator threshold.
`timescale 1ns/1ps
`default_nettype none
`include "ertr_map.vh"

module ertr_regs #(
   parameter ADDR_W = 8,
   parameter ECNT_W = 5
) (
   // Clock, reset, enable
   input  wire              pclk,
   input  wire              presetn,
   input  wire              ce,
   // APB slave
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [ADDR_W-1:0] paddr,
   input  wire [31:0]       pwdata,
   output wire [31:0]       prdata,
   output wire              pready,
   output wire              pslverr,
   // Same-clock configuration
   input  wire [2:0]        echo_threshold_sel,
   input  wire [ECNT_W-1:0] expected_echo_count,
   input  wire              base_div2,
   // Asynchronous pins
   input  wire              meas_start_pin,
   input  wire              echo_zc_pin,
   input  wire              echo_over_pin,
   // Analog front end controls
   output wire [2:0]        amp_gain_select,
   output wire              amp_bypass,
   output wire              input_amp_bypass,
   output wire              input_amp_feedback_sel,
   output wire [9:0]        timing_value,
   output wire              short_flight_force,
   output wire [2:0]        short_flight_blank_len,
   output wire [1:0]        listen_window_len,
   // Status
   output wire              fault_out_n,
   output wire [1:0]        meas_phase,
   output wire              avg_count_clear,
   output wire              chan_sel_reset
);

   localparam ST_IDLE   = 2'b00;
   localparam ST_BLANK  = 2'b01;
   localparam ST_LISTEN = 2'b10;

   // Byte address of a register index
   function [ADDR_W-1:0] reg_addr;
      input [5:0]        idx;
      reg   [ADDR_W+7:0] wide;
      begin
         // Widened first so a narrow address bus never needs a zero replication
         wide     = {{ADDR_W{1'b0}}, idx, 2'b00};
         reg_addr = wide[ADDR_W-1:0];
      end
   endfunction

   // Base-period length doubled per code step
   function [10:0] period_len;
      input [10:0] base;
      input [2:0]  code;
      begin
         period_len = base << code;
      end
   endfunction

   // Registers
   reg  [7:0]        gain_win_q;
   reg  [7:0]        win_lo_q;
   reg  [7:0]        limits_q;
   reg  [2:0]        fault_q;
   reg  [2:0]        fault_d;
   reg  [1:0]        state_q;
   reg  [1:0]        state_d;
   reg  [10:0]       cnt_q;
   reg  [10:0]       cnt_d;
   reg  [ECNT_W-1:0] echo_cnt_q;
   reg  [ECNT_W-1:0] echo_cnt_d;
   reg               start_last_q;
   reg               zc_last_q;
   reg               pready_q;
   reg               pslverr_q;
   reg  [31:0]       prdata_q;
   reg               fault_out_n_q;
   reg               avg_clear_q;
   reg               chsel_rst_q;

   wire              start_s;
   wire              zc_s;
   wire              over_s;
   wire              tick;
   wire              start_rise;
   wire              zc_rise;
   wire              wr_acc;
   wire              map_hit;
   wire              abort;
   wire              clr_all;
   wire [10:0]       blank_len;
   wire [10:0]       win_len;
   reg               timeout;
   reg  [31:0]       rd_word;

   ertr_sync #(
      .W (3)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .ce       (ce),
      .async_in ({meas_start_pin, echo_zc_pin, echo_over_pin}),
      .sync_out ({start_s, zc_s, over_s})
   );

   ertr_tick u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .run     (state_q != ST_IDLE),
      .div2    (base_div2),
      .tick    (tick)
   );

   assign start_rise = start_s & ~start_last_q;
   assign zc_rise    = zc_s & ~zc_last_q;

   // APB: answer on the second access cycle, write lands with pready
   assign wr_acc  = psel & penable & pready_q & pwrite;
   assign map_hit = (paddr == reg_addr(`ERTR_IDX_GAIN_WIN)) |
                    (paddr == reg_addr(`ERTR_IDX_WIN_LO)) |
                    (paddr == reg_addr(`ERTR_IDX_FAULT)) |
                    (paddr == reg_addr(`ERTR_IDX_LIMITS));

   assign abort   = wr_acc & (paddr == reg_addr(`ERTR_IDX_FAULT)) &
                    pwdata[`ERTR_FLT_MISSING];
   assign clr_all = wr_acc & (paddr == reg_addr(`ERTR_IDX_FAULT)) &
                    pwdata[`ERTR_FLT_STRONG];

   assign blank_len = period_len(`ERTR_BLANK_BASE,
                         limits_q[`ERTR_LIM_BLANK_MSB:`ERTR_LIM_BLANK_LSB]);
   assign win_len   = period_len(`ERTR_WINDOW_BASE,
                         {1'b0, limits_q[`ERTR_LIM_WIN_MSB:0]});

   // Read multiplexer
   always @* begin
      rd_word = 32'h00000000;
      if (paddr == reg_addr(`ERTR_IDX_GAIN_WIN)) begin
         rd_word[7:0] = gain_win_q;
      end else if (paddr == reg_addr(`ERTR_IDX_WIN_LO)) begin
         rd_word[7:0] = win_lo_q;
      end else if (paddr == reg_addr(`ERTR_IDX_FAULT)) begin
         rd_word[2:0] = fault_q;
      end else if (paddr == reg_addr(`ERTR_IDX_LIMITS)) begin
         rd_word[7:0] = limits_q;
      end
   end

   // Measurement sequencer
   always @* begin
      state_d    = state_q;
      cnt_d      = cnt_q;
      echo_cnt_d = echo_cnt_q;
      timeout    = 1'b0;
      case (state_q)
         ST_IDLE: begin
            cnt_d      = 11'h000;
            echo_cnt_d = {ECNT_W{1'b0}};
            if (start_rise) begin
               if (limits_q[`ERTR_LIM_FORCE]) begin
                  state_d = ST_BLANK;
               end else begin
                  state_d = ST_LISTEN;
               end
            end
         end
         ST_BLANK: begin
            // Echoes inside the blanking period are ignored
            if (tick) begin
               if (cnt_q == blank_len - 11'h001) begin
                  cnt_d   = 11'h000;
                  state_d = ST_LISTEN;
               end else begin
                  cnt_d = cnt_q + 11'h001;
               end
            end
         end
         ST_LISTEN: begin
            if (zc_rise && echo_cnt_q != {ECNT_W{1'b1}}) begin
               echo_cnt_d = echo_cnt_q + {{(ECNT_W-1){1'b0}}, 1'b1};
            end
            if (zc_rise && echo_cnt_d >= expected_echo_count) begin
               state_d = ST_IDLE;
            end else if (tick) begin
               if (cnt_q == win_len - 11'h001) begin
                  // Counter saturates when the timeout is disabled
                  if (!limits_q[`ERTR_LIM_TO_DIS]) begin
                     timeout = 1'b1;
                     state_d = ST_IDLE;
                  end
               end else begin
                  cnt_d = cnt_q + 11'h001;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      if (abort) begin
         state_d = ST_IDLE;
      end
   end

   // Fault flags: a new event wins over a clear in the same cycle
   always @* begin
      fault_d = fault_q;
      if (clr_all) begin
         fault_d = 3'h0;
      end else if (wr_acc && paddr == reg_addr(`ERTR_IDX_FAULT) &&
                   pwdata[`ERTR_FLT_MISSING]) begin
         fault_d[`ERTR_FLT_MISSING] = 1'b0;
      end
      if (timeout && echo_cnt_q == {ECNT_W{1'b0}}) begin
         fault_d[`ERTR_FLT_MISSING] = 1'b1;
      end
      if (timeout && echo_cnt_q != {ECNT_W{1'b0}} &&
          echo_cnt_q < expected_echo_count) begin
         fault_d[`ERTR_FLT_WEAK] = 1'b1;
      end
      if (state_q == ST_LISTEN && over_s &&
          echo_threshold_sel == `ERTR_THLD_MAX) begin
         fault_d[`ERTR_FLT_STRONG] = 1'b1;
      end
   end

   // Register file
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gain_win_q <= `ERTR_RST_GAIN_WIN;
         win_lo_q   <= `ERTR_RST_WIN_LO;
         limits_q   <= `ERTR_RST_LIMITS;
      end else if (ce && wr_acc) begin
         if (paddr == reg_addr(`ERTR_IDX_GAIN_WIN)) begin
            gain_win_q <= pwdata[7:0];
         end
         if (paddr == reg_addr(`ERTR_IDX_WIN_LO)) begin
            win_lo_q <= pwdata[7:0];
         end
         if (paddr == reg_addr(`ERTR_IDX_LIMITS)) begin
            limits_q <= pwdata[7:0];
         end
      end
   end

   // APB handshake
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else if (ce) begin
         if (psel && penable && !pready_q) begin
            pready_q  <= 1'b1;
            pslverr_q <= ~map_hit;
            prdata_q  <= pwrite ? 32'h00000000 : rd_word;
         end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
         end
      end
   end

   // Sequencer, flags and pin state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q       <= ST_IDLE;
         cnt_q         <= 11'h000;
         echo_cnt_q    <= {ECNT_W{1'b0}};
         fault_q       <= `ERTR_RST_FAULT;
         start_last_q  <= 1'b0;
         zc_last_q     <= 1'b0;
         fault_out_n_q <= 1'b1;
         avg_clear_q   <= 1'b0;
         chsel_rst_q   <= 1'b0;
      end else if (ce) begin
         state_q       <= state_d;
         cnt_q         <= abort ? 11'h000 : cnt_d;
         echo_cnt_q    <= abort ? {ECNT_W{1'b0}} : echo_cnt_d;
         fault_q       <= fault_d;
         start_last_q  <= start_s;
         zc_last_q     <= zc_s;
         fault_out_n_q <= ~(|fault_d);
         avg_clear_q   <= abort;
         chsel_rst_q   <= abort;
      end
   end

   // Outputs
   assign prdata                 = prdata_q;
   assign pready                 = pready_q;
   assign pslverr                = pslverr_q;
   assign amp_gain_select        = gain_win_q[`ERTR_GAIN_MSB:`ERTR_GAIN_LSB];
   assign amp_bypass             = gain_win_q[`ERTR_AMP_BYP];
   assign input_amp_bypass       = gain_win_q[`ERTR_IAMP_BYP];
   assign input_amp_feedback_sel = gain_win_q[`ERTR_IAMP_FB];
   assign timing_value           = {gain_win_q[`ERTR_WIN_HI_MSB:0], win_lo_q};
   assign short_flight_force     = limits_q[`ERTR_LIM_FORCE];
   assign short_flight_blank_len = limits_q[`ERTR_LIM_BLANK_MSB:`ERTR_LIM_BLANK_LSB];
   assign listen_window_len      = limits_q[`ERTR_LIM_WIN_MSB:0];
   assign fault_out_n            = fault_out_n_q;
   assign meas_phase             = state_q;
   assign avg_count_clear        = avg_clear_q;
   assign chan_sel_reset         = chsel_rst_q;

endmodule // ertr_regs

`default_nettype wire

// ==== hdl/ertr_sync.v ====
// Two-stage synchroniser for pins entering the pclk domain.
// Assumes pclk is running; holds state while ce is low.
`timescale 1ns/1ps
`default_nettype none

module ertr_sync #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         pclk,
   input  wire         presetn,
   input  wire         ce,
   // Data
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // First stage feeds the second stage only
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else if (ce) begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule // ertr_sync

`default_nettype wire

// ==== hdl/ertr_tick.v ====
// Base period strobe: pclk divided by one or two.
// Assumes run is low outside a measurement so each one starts in phase.
`timescale 1ns/1ps
`default_nettype none

module ertr_tick (
   // Clock and reset
   input  wire pclk,
   input  wire presetn,
   input  wire ce,
   // Control
   input  wire run,
   input  wire div2,
   // Strobe
   output wire tick
);

   reg phase_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_q <= 1'b0;
      end else if (ce) begin
         if (!run) begin
            phase_q <= 1'b0;
         end else begin
            phase_q <= ~phase_q;
         end
      end
   end

   // Divide by two fires on every second cycle of the run
   assign tick = run & ce & (~div2 | phase_q);

endmodule // ertr_tick

`default_nettype wire

// ==== testbench/echo_receive_error_timing_regs_bench.sv ====
// Self-checking bench for the echo fault and timing registers.
// Assumes ertr_regs with default parameters and the host pin model.
`timescale 1ns/1ps
`default_nettype none
module echo_receive_error_timing_regs_bench;
   logic        pclk, presetn, psel, penable, pwrite, div2, pready, fo_n;
   logic        ab, iab, ifb, sf, st, zc, ov, se, csr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, d;
   logic [2:0]  thr, gs, bl;
   logic [4:0]  ecnt;
   logic [9:0]  tv;
   logic [1:0]  wl, ph;
   logic [31:0] exp_q[$];
   integer      miscompares = 0, total_checks = 0, seed = 65666, i, n;

   ertr_regs uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(se), .echo_threshold_sel(thr),
      .expected_echo_count(ecnt), .base_div2(div2), .meas_start_pin(st),
      .echo_zc_pin(zc), .echo_over_pin(ov), .amp_gain_select(gs), .amp_bypass(ab),
      .input_amp_bypass(iab), .input_amp_feedback_sel(ifb), .timing_value(tv),
      .short_flight_force(sf), .short_flight_blank_len(bl), .listen_window_len(wl),
      .fault_out_n(fo_n), .meas_phase(ph), .avg_count_clear(), .chan_sel_reset(csr));
   ertr_host_pins host (.pclk(pclk), .start_pin(st), .zc_pin(zc), .over_pin(ov));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Reads note their expected word; the monitor compares it
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
      integer k;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= dt;
         if (!w) exp_q.push_back(dt);
         @(posedge pclk) penable <= 1'b1;
         k = 0;
         // Request stands until pready is seen high at a rising edge
         do begin
            @(posedge pclk);
            k++;
         end while (pready !== 1'b1 && k < 50);
         if (pready !== 1'b1) miscompares++;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic wt(input integer c);
      repeat (c) @(posedge pclk);
      #1;
   endtask

   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) chk("prdata", exp_q.pop_front(), prdata);
      // Only 8'h24 is used as an unmapped address
      if (psel && penable && pready === 1'b1) chk("pslverr", paddr == 8'h24, se);
   end

   task end_of_test;
      begin
         if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   initial begin
      #200000;
      miscompares++;
      end_of_test;
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, div2, presetn} = 0;
      thr = 3'h3;
      ecnt = 5'h03;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 8'h14, 32'h0);
      apb(0, 8'h18, 32'h0);
      apb(0, 8'h1C, 32'h0);
      apb(0, 8'h20, 32'h19);
      apb(0, 8'h24, 32'h0);
      for (i = 0; i < 6; i++) begin
         d = $random(seed) & 32'hFF;
         apb(1, 8'h14, d);
         apb(0, 8'h14, d);
         chk("amp_ctl", d[7:2], {gs, ab, iab, ifb});
         apb(1, 8'h18, ~d & 32'hFF);
         apb(0, 8'h18, ~d & 32'hFF);
         chk("timing", {d[1:0], ~d[7:0]}, tv);
         apb(1, 8'h20, d);
         apb(0, 8'h20, d);
         chk("limits", {d[6:3], d[1:0]}, {sf, bl, wl});
         apb(1, 8'h1C, d);
         apb(0, 8'h1C, 32'h0);
         apb(1, 8'h24, d);
         apb(0, 8'h24, 32'h0);
      end
      // No echo: every window code, one run at half base rate
      for (i = 0; i < 4; i++) begin
         apb(1, 8'h20, i);
         div2 <= (i == 1);
         n = (128 << i) * ((i == 1) ? 2 : 1);
         host.pulse_start;
         wt(n - 8);
         chk("fault_out_n", 1, fo_n);
         chk("phase", 2, ph);
         wt(16);
         chk("fault_out_n", 0, fo_n);
         apb(0, 8'h1C, 32'h2);
         apb(1, 8'h1C, 32'h2);
         apb(0, 8'h1C, 32'h0);
      end
      div2 <= 1'b0;
      // Forced short flight, timeout off, every blanking code
      for (i = 0; i < 8; i++) begin
         apb(1, 8'h20, 32'h44 | (i << 3));
         host.pulse_start;
         wt((8 << i) - 4);
         chk("phase", 1, ph);
         wt(8);
         chk("phase", 2, ph);
         if (i == 0) wt(200);
         if (i == 0) chk("phase", 2, ph);
         apb(1, 8'h1C, 32'h2);
         #1;
         chk("chan_sel_reset", 1, csr);
         wt(1);
         chk("phase", 0, ph);
         chk("chan_sel_reset", 0, csr);
      end
      // One echo of three expected
      apb(1, 8'h20, 32'h0);
      host.pulse_start;
      wt(20);
      host.pulse_zc;
      wt(130);
      apb(0, 8'h1C, 32'h4);
      apb(1, 8'h1C, 32'h2);
      apb(0, 8'h1C, 32'h4);
      apb(1, 8'h1C, 32'h1);
      apb(0, 8'h1C, 32'h0);
      chk("fault_out_n", 1, fo_n);
      // Overload at the largest threshold, then below it
      thr <= 3'h7;
      host.set_over(1'b1);
      host.pulse_start;
      wt(150);
      apb(0, 8'h1C, 32'h3);
      apb(1, 8'h1C, 32'h1);
      apb(0, 8'h1C, 32'h0);
      thr <= 3'h3;
      host.pulse_start;
      wt(150);
      apb(0, 8'h1C, 32'h2);
      apb(1, 8'h1C, 32'h3);
      host.set_over(1'b0);
      wt(4);
      end_of_test;
   end
endmodule // echo_receive_error_timing_regs_bench
`default_nettype wire

// ==== testbench/ertr_host_pins.sv ====
// Host side pin model: start trigger, zero crossings, overload.
// Assumes pulses of four pclk survive the two-flop synchroniser.
`timescale 1ns/1ps
`default_nettype none
module ertr_host_pins (
   // Clock
   input wire logic pclk,
   // Pins
   output var logic start_pin,
   output var logic zc_pin,
   output var logic over_pin
);
   initial begin
      start_pin = 1'b0;
      zc_pin = 1'b0;
      over_pin = 1'b0;
   end
   task pulse_start;
      begin
         @(posedge pclk) start_pin <= 1'b1;
         repeat (4) @(posedge pclk);
         start_pin <= 1'b0;
      end
   endtask
   task pulse_zc;
      begin
         @(posedge pclk) zc_pin <= 1'b1;
         repeat (4) @(posedge pclk);
         zc_pin <= 1'b0;
      end
   endtask
   task set_over(input logic v);
      @(posedge pclk) over_pin <= v;
   endtask
endmodule // ertr_host_pins
`default_nettype wire

// ==== testbench/ertr_regs_checker.sv ====
// Port assertions for the echo fault and timing registers.
// Assumes one pclk domain and an async active-low presetn.
`timescale 1ns/1ps
`default_nettype none
module ertr_regs_checker #(
   parameter ADDR_W = 8
) (
   // Bus
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   // Block side
   input wire logic [2:0]        echo_threshold_sel,
   input wire logic [2:0]        amp_gain_select,
   input wire logic [9:0]        timing_value,
   input wire logic [1:0]        listen_window_len,
   input wire logic              fault_out_n,
   input wire logic [1:0]        meas_phase,
   input wire logic              avg_count_clear
);
   wire done = psel && penable && pready;
   wire wr   = done && pwrite;
   wire rd   = done && !pwrite;
   wire flt  = paddr == 8'h1C;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   gain_field_a: assert property (wr && paddr == 8'h14 |=>
      amp_gain_select == $past(pwdata[7:5]) && timing_value[9:8] == $past(pwdata[1:0]))
      else $error("gain register write not applied");
   low_field_a: assert property (wr && paddr == 8'h18 |=>
      timing_value[7:0] == $past(pwdata[7:0])) else $error("low timing write lost");
   window_field_a: assert property (wr && paddr == 8'h20 |=>
      listen_window_len == $past(pwdata[1:0])) else $error("window code not applied");
   rsvd_zero_a: assert property (rd && flt |-> prdata[31:3] == 29'h0)
      else $error("fault reserved bits not zero");
   fault_pin_a: assert property (rd && flt |->
      $past(fault_out_n) == (prdata[2:0] == 3'h0)) else $error("fault pin disagrees with flags");
   strong_qual_a: assert property ($fell(fault_out_n) && meas_phase == 2'h2 |->
      $past(echo_threshold_sel) == 3'h7) else $error("strong flag with low threshold");
   abort_pulse_a: assert property (wr && flt && pwdata[1] |=>
      meas_phase == 2'h0 && avg_count_clear ##1 !avg_count_clear) else $error("abort wrong");
   clear_all_a: assert property (wr && flt && pwdata[0] |=> fault_out_n)
      else $error("fault pin not released");
   flag_source_a: assert property ($fell(fault_out_n) |-> $past(meas_phase) == 2'h2)
      else $error("flag raised outside listening");
   cover property (wr && flt && pwdata[1]);
   cover property ($fell(fault_out_n));
   cover property (meas_phase == 2'h1);
endmodule // ertr_regs_checker
bind ertr_regs ertr_regs_checker #(.ADDR_W(ADDR_W)) chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .echo_threshold_sel(echo_threshold_sel),
   .amp_gain_select(amp_gain_select), .timing_value(timing_value),
   .listen_window_len(listen_window_len), .fault_out_n(fault_out_n),
   .meas_phase(meas_phase), .avg_count_clear(avg_count_clear)
);
`default_nettype wire
